/* logic/i2cms_pkg.sv */
// package: constants and types of the i2c master sequencer
package i2cms_pkg;
  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int BYTE_W = 8;   // data and address byte width
  localparam int CNT_W  = 7;   // bit-timing counter width
  localparam int BIT_W  = 4;   // bit index within a byte
  localparam logic [BIT_W-1:0] ACK_BIT = 4'h8;  // ninth bit is acknowledge
  // -----------------------------------------------------------------
  // timing in link-clock cycles, indexed by speed reduction 0..3
  // -----------------------------------------------------------------
  localparam logic [CNT_W-1:0] STD_LOW  [4] = '{7'h2c, 7'h30, 7'h34, 7'h38};
  localparam logic [CNT_W-1:0] STD_HIGH [4] = '{7'h24, 7'h28, 7'h2c, 7'h30};
  localparam logic [CNT_W-1:0] STD_HOLD     = 7'h08;
  localparam logic [CNT_W-1:0] FST_LOW  [4] = '{7'h0c, 7'h0e, 7'h0e, 7'h10};
  localparam logic [CNT_W-1:0] FST_HIGH [4] = '{7'h08, 7'h08, 7'h0a, 7'h0a};
  localparam logic [CNT_W-1:0] FST_HOLD     = 7'h04;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RX_RST  = 8'h00;  // receive data
  localparam logic [BYTE_W-1:0] REG_RST = 8'h00;  // address and tx data
  // -----------------------------------------------------------------
  // link-side sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_RS, S_START, S_BIT, S_WAIT, S_STOP, S_BUF
  } i2cms_state_t;
endpackage : i2cms_pkg

/* logic/i2cms_top.sv */
// i2c master sequencer: software-side control and link-side bit engine
`timescale 1ns/1ps
// Contract
// - start request while stopped drives start condition
// - restart plus start while active drives repeated start
// - address and direction out msb first, ack sampled
// - after address ack enter control wait state
// - driven address byte captured as receive data
// - transmit byte msb first, ack and byte captured
// - receive samples at end of scl high, drives ack value
// - receive data updated after ack, ack captured
// - after receive ack enter control wait state
// - entering wait state raises interrupt
// - start request in wait resumes next byte
// - stop request in wait generates stop condition
// - restart plus start in wait gives repeated start
// - after stop condition raise interrupt again
// - bit mismatch sets error, keeps driving data unless clock sync selected
// - control write clears transmit error flag, unless an error event arrives in the same cycle
// - standard mode bit timing per reduction table
// - fast mode bit timing per reduction table
// - clearing enable returns status and sequencer to initial
// - busy set on any start, cleared on stop
// - speed select zero standard, one fast
// - stop clears start; start needs enable
module i2cms_top (
  input  wire logic                         clk,               // system clock
  input  wire logic                         rst_n,             // async reset
  input  wire logic                         fast_sys_clock,    // link bit clock
  input  wire logic                         iface_enable_bit,  // interface enable
  input  wire logic                         speed_select_bit,  // 0 standard, 1 fast
  input  wire logic                         slowdown_sel_hi,   // reduction msb
  input  wire logic                         slowdown_sel_lo,   // reduction lsb
  input  wire logic                         clock_sync_select, // clock stretch follow
  input  wire logic [i2cms_pkg::BYTE_W-1:0] target_addr,       // address and direction
  input  wire logic [i2cms_pkg::BYTE_W-1:0] tx_data,           // transmit byte
  input  wire logic                         ack_drive_value,   // ack level on receive
  input  wire logic                         ctrl_wr,           // control write strobe
  input  wire logic                         ctrl_go,           // start request written
  input  wire logic                         ctrl_halt,         // stop request written
  input  wire logic                         ctrl_restart,      // restart request written
  output logic                              xfer_go_bit,       // start request state
  output logic [i2cms_pkg::BYTE_W-1:0]      rx_data,           // receive data
  output logic                              ack_seen_bit,      // received ack
  output logic                              arb_error_flag,    // transmit error
  output logic                              bus_busy_flag,     // bus busy
  output logic                              bus_iface_irq,     // interrupt pulse
  input  wire logic                         scl_in,            // clock line level
  output logic                              scl_out,           // clock drive value
  output logic                              scl_oe,            // clock pulled low
  input  wire logic                         sda_in,            // data line level
  output logic                              sda_out,           // data drive value
  output logic                              sda_oe             // data pulled low
);
  import i2cms_pkg::*;

  // -----------------------------------------------------------------
  // timing lookup
  // -----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] t_low(input logic f, input logic [1:0] r);
    t_low = f ? FST_LOW[r] : STD_LOW[r];
  endfunction : t_low
  function automatic logic [CNT_W-1:0] t_high(input logic f, input logic [1:0] r);
    t_high = f ? FST_HIGH[r] : STD_HIGH[r];
  endfunction : t_high

  // -----------------------------------------------------------------
  // system side: command snapshot and status
  // -----------------------------------------------------------------
  logic              cmd_tgl_r, cmd_tgl_nxt;   // command toggle
  logic              cmd_go_r, cmd_halt_r, cmd_rs_r;
  logic [BYTE_W-1:0] addr_r, txd_r;            // stable copies for link
  logic              ackv_r, spd_r, syn_r;
  logic [1:0]        slow_r;
  logic              go_r, go_nxt;             // start request bit
  logic [BYTE_W-1:0] rx_r, rx_nxt;
  logic              ack_r, ack_nxt, err_r, err_nxt, irq_r, irq_nxt, busy_r;
  logic              e1_r, e2_r, e3_r, b1_r, b2_r;  // link-to-system syncs
  logic              evt_tgl_l, stop_l, ack_l, err_l;  // link event data
  logic [BYTE_W-1:0] rx_l;
  logic              busy_l;
  logic              evt_edge;                 // link event arrived

  assign evt_edge = e2_r ^ e3_r;

  // next values of the system-side state
  always_comb begin
    cmd_tgl_nxt = cmd_tgl_r;
    go_nxt      = go_r;
    rx_nxt      = rx_r;
    ack_nxt     = ack_r;
    err_nxt     = err_r;
    irq_nxt     = 1'b0;
    if (ctrl_wr) begin
      cmd_tgl_nxt = ~cmd_tgl_r;
      err_nxt     = 1'b0;
      if (ctrl_halt) go_nxt = 1'b0;
      else if (ctrl_go) go_nxt = 1'b1;
    end
    if (evt_edge) begin
      irq_nxt = 1'b1;
      if (stop_l) begin
        go_nxt = 1'b0;                         // transfer over
      end else begin
        rx_nxt  = rx_l;
        ack_nxt = ack_l;
        if (err_l) err_nxt = 1'b1;             // set wins over clear
      end
    end
  end

  // registers of the system side; disable clears status and receive data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {cmd_tgl_r, cmd_go_r, cmd_halt_r, cmd_rs_r} <= 4'h0;
      {ackv_r, spd_r, syn_r, slow_r}              <= 5'h00;
      addr_r <= REG_RST;
      txd_r  <= REG_RST;
      {go_r, ack_r, err_r, irq_r, busy_r}         <= 5'h00;
      rx_r   <= RX_RST;
      {e1_r, e2_r, e3_r, b1_r, b2_r}              <= 5'h00;
    end else begin
      e1_r <= evt_tgl_l;
      e2_r <= e1_r;
      e3_r <= e2_r;
      b1_r <= busy_l;
      b2_r <= b1_r;
      if (!iface_enable_bit) begin
        {go_r, ack_r, err_r, irq_r, busy_r} <= 5'h00;
        rx_r <= RX_RST;
      end else begin
        cmd_tgl_r <= cmd_tgl_nxt;
        go_r      <= go_nxt;
        rx_r      <= rx_nxt;
        ack_r     <= ack_nxt;
        err_r     <= err_nxt;
        irq_r     <= irq_nxt;
        busy_r    <= b2_r;
        if (ctrl_wr) begin
          cmd_go_r   <= ctrl_go & ~ctrl_halt & ~go_r;      // fresh start
          cmd_halt_r <= ctrl_halt;
          cmd_rs_r   <= ctrl_restart & ctrl_go & go_r;
          addr_r <= target_addr;
          txd_r  <= tx_data;
          ackv_r <= ack_drive_value;
          spd_r  <= speed_select_bit;
          slow_r <= {slowdown_sel_hi, slowdown_sel_lo};
          syn_r  <= clock_sync_select;
          if (go_r && ctrl_go && !ctrl_halt) cmd_go_r <= 1'b1;  // resume
        end
      end
    end
  end

  assign xfer_go_bit    = go_r;
  assign rx_data        = rx_r;
  assign ack_seen_bit   = ack_r;
  assign arb_error_flag = err_r;
  assign bus_busy_flag  = busy_r;
  assign bus_iface_irq  = irq_r;

  // -----------------------------------------------------------------
  // link side: synchronisers
  // -----------------------------------------------------------------
  logic lr1_r, lrst_n;                         // link reset release sync
  logic c1_r, c2_r, c3_r, n1_r, en_l;          // command toggle, enable
  logic sc1_r, scl_s, sd1_r, sda_s, sda_p;     // line samples
  logic cmd_new;

  always_ff @(posedge fast_sys_clock or negedge rst_n) begin
    if (!rst_n) begin
      {lr1_r, lrst_n} <= 2'h0;
    end else begin
      lr1_r  <= 1'b1;
      lrst_n <= lr1_r;
    end
  end

  // two-stage syncs of level and toggle
  always_ff @(posedge fast_sys_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      {c1_r, c2_r, c3_r, n1_r, en_l}      <= 5'h00;
      {sc1_r, scl_s, sd1_r, sda_s, sda_p} <= 5'h1f;
    end else begin
      c1_r  <= cmd_tgl_r;
      c2_r  <= c1_r;
      c3_r  <= c2_r;
      n1_r  <= iface_enable_bit;
      en_l  <= n1_r;
      sc1_r <= scl_in;
      scl_s <= sc1_r;
      sd1_r <= sda_in;
      sda_s <= sd1_r;
      sda_p <= sda_s;
    end
  end
  assign cmd_new = c2_r ^ c3_r;

  // -----------------------------------------------------------------
  // link side: bit sequencer
  // -----------------------------------------------------------------
  i2cms_state_t      st_r, st_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt, tlo, thi, thd;
  logic [BIT_W-1:0]  bit_r, bit_nxt;
  logic [BYTE_W-1:0] sh_r, sh_nxt, rx_nxt_l;
  logic              ph_r, ph_nxt, adr_r, adr_nxt, er_r, er_nxt;
  logic              scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic              evt_nxt, stop_nxt, ack_nxt_l, err_nxt_l, busy_nxt;
  logic              txm, dv;

  assign tlo = t_low(spd_r, slow_r);
  assign thi = t_high(spd_r, slow_r);
  assign thd = spd_r ? FST_HOLD : STD_HOLD;
  assign txm = adr_r | ~addr_r[0];             // driving this byte

  // level to put on the data line for the current bit
  always_comb begin
    if (bit_r == ACK_BIT) dv = txm ? 1'b1 : ackv_r;
    else dv = txm ? sh_r[BYTE_W-1] : 1'b1;
    if (syn_r && er_r) dv = 1'b1;                    // release after loss
  end

  // next values of the sequencer
  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r + 7'h01; bit_nxt = bit_r; sh_nxt = sh_r;
    ph_nxt = ph_r; adr_nxt = adr_r; er_nxt = er_r;
    scl_oe_nxt = scl_oe_r; sda_oe_nxt = sda_oe_r;
    evt_nxt = evt_tgl_l; stop_nxt = stop_l; ack_nxt_l = ack_l;
    err_nxt_l = err_l; rx_nxt_l = rx_l;
    busy_nxt = busy_l;
    if (scl_s && sda_p && !sda_s) busy_nxt = 1'b1;
    if (scl_s && !sda_p && sda_s) busy_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        scl_oe_nxt = 1'b0; sda_oe_nxt = 1'b0;
        if (cmd_new && cmd_go_r) begin
          sda_oe_nxt = 1'b1; cnt_nxt = '0;     // start condition
          st_nxt = S_START; sh_nxt = addr_r; adr_nxt = 1'b1; bit_nxt = '0;
        end
      end
      S_RS: begin
        if (!ph_r) begin
          if (cnt_r == thd - 7'h01) sda_oe_nxt = 1'b0;
          if (cnt_r == tlo - 7'h01) begin
            scl_oe_nxt = 1'b0; ph_nxt = 1'b1; cnt_nxt = '0;
          end
        end else if (cnt_r == tlo - 7'h01) begin
          sda_oe_nxt = 1'b1; cnt_nxt = '0; st_nxt = S_START;
          sh_nxt = addr_r; adr_nxt = 1'b1; bit_nxt = '0;
        end
      end
      S_START: if (cnt_r == thi - 7'h01) begin
        scl_oe_nxt = 1'b1; st_nxt = S_BIT; ph_nxt = 1'b0; cnt_nxt = '0;
      end
      S_BIT: begin
        if (!ph_r) begin                       // low phase
          if (cnt_r == thd - 7'h01) sda_oe_nxt = ~dv;
          if (cnt_r == tlo - 7'h01) begin
            scl_oe_nxt = 1'b0; ph_nxt = 1'b1; cnt_nxt = '0;
          end
        end else begin                         // high phase
          if (syn_r && !scl_s) cnt_nxt = cnt_r;  // follow a stretched clock
          else if (cnt_r == thi - 7'h01) begin
            scl_oe_nxt = 1'b1; ph_nxt = 1'b0; cnt_nxt = '0;
            bit_nxt = bit_r + 4'h1;
            if (bit_r != ACK_BIT) begin
              sh_nxt = {sh_r[BYTE_W-2:0], sda_s};
              if (txm && dv && !sda_s) er_nxt = 1'b1;
            end else begin                     // byte done
              st_nxt = S_WAIT; evt_nxt = ~evt_tgl_l; stop_nxt = 1'b0;
              rx_nxt_l = sh_r; ack_nxt_l = sda_s; err_nxt_l = er_r;
              er_nxt = 1'b0;
            end
          end
        end
      end
      S_WAIT: begin
        scl_oe_nxt = 1'b1;
        cnt_nxt = '0; ph_nxt = 1'b0;
        if (cmd_new && cmd_halt_r) st_nxt = S_STOP;
        else if (cmd_new && cmd_rs_r) st_nxt = S_RS;
        else if (cmd_new && cmd_go_r) begin
          st_nxt = S_BIT; bit_nxt = '0; adr_nxt = 1'b0;
          sh_nxt = addr_r[0] ? 8'hff : txd_r;
        end
      end
      S_STOP: begin
        if (!ph_r) begin
          if (cnt_r == thd - 7'h01) sda_oe_nxt = 1'b1;
          if (cnt_r == tlo - 7'h01) begin
            scl_oe_nxt = 1'b0; ph_nxt = 1'b1; cnt_nxt = '0;
          end
        end else if (cnt_r == thi - 7'h01) begin
          sda_oe_nxt = 1'b0; cnt_nxt = '0; st_nxt = S_BUF;
          evt_nxt = ~evt_tgl_l; stop_nxt = 1'b1;
        end
      end
      S_BUF: if (cnt_r == tlo - 7'h01) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // sequencer registers; disable returns to idle
  always_ff @(posedge fast_sys_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      st_r <= S_IDLE; cnt_r <= '0; bit_r <= '0; sh_r <= REG_RST; rx_l <= RX_RST;
      {ph_r, adr_r, er_r, scl_oe_r, sda_oe_r} <= 5'h00;
      {evt_tgl_l, stop_l, ack_l, err_l, busy_l} <= 5'h00;
    end else if (!en_l) begin
      st_r <= S_IDLE; cnt_r <= '0; bit_r <= '0; sh_r <= REG_RST; rx_l <= RX_RST;
      {ph_r, adr_r, er_r, scl_oe_r, sda_oe_r} <= 5'h00;
      {stop_l, ack_l, err_l, busy_l} <= 4'h0;
    end else begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt;
      ph_r <= ph_nxt; adr_r <= adr_nxt; er_r <= er_nxt;
      scl_oe_r <= scl_oe_nxt; sda_oe_r <= sda_oe_nxt;
      evt_tgl_l <= evt_nxt; stop_l <= stop_nxt; ack_l <= ack_nxt_l;
      err_l <= err_nxt_l; rx_l <= rx_nxt_l; busy_l <= busy_nxt;
    end
  end

  assign scl_oe  = scl_oe_r;
  assign sda_oe  = sda_oe_r;
  assign scl_out = 1'b0;                       // open drain: only pulls low
  assign sda_out = 1'b0;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  sequence s_halt_wr;
    ctrl_wr && ctrl_halt && iface_enable_bit;
  endsequence
  a_go_needs_enable: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(go_r) |-> $past(iface_enable_bit)) else $error("start bit set while disabled");
  a_halt_clears_go: assert property (@(posedge clk) disable iff (!rst_n)
    s_halt_wr |=> !go_r) else $error("stop write left start bit set");
  a_err_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr && !evt_edge |=> !err_r) else $error("control write kept error");
  a_irq_on_event: assert property (@(posedge clk) disable iff (!rst_n)
    evt_edge && iface_enable_bit |=> irq_r) else $error("event gave no interrupt");
  a_disable_clears: assert property (@(posedge clk) disable iff (!rst_n)
    !iface_enable_bit |=> !go_r && !err_r && !ack_r && rx_r == RX_RST)
    else $error("disable left state");
  a_start_shape: assert property (@(posedge fast_sys_clock) disable iff (!lrst_n)
    st_r == S_IDLE && en_l && cmd_new && cmd_go_r |=> sda_oe_r && !scl_oe_r)
    else $error("start condition not driven");
  a_wait_holds_scl: assert property (@(posedge fast_sys_clock) disable iff (!lrst_n)
    st_r == S_WAIT |-> scl_oe_r) else $error("clock released in wait");
  a_wait_event: assert property (@(posedge fast_sys_clock) disable iff (!lrst_n)
    $rose(st_r == S_WAIT) |-> $changed(evt_tgl_l)) else $error("wait without event");
  a_low_min: assert property (@(posedge fast_sys_clock) disable iff (!lrst_n)
    $rose(scl_oe_r) && st_r == S_BIT && en_l |=> scl_oe_r [*8])
    else $error("clock low too short");
  a_busy_start: assert property (@(posedge fast_sys_clock) disable iff (!lrst_n)
    en_l && scl_s && sda_p && !sda_s |=> busy_l) else $error("start missed by busy");
endmodule : i2cms_top

/* verification/i2cms_slave.sv */
// far-side i2c slave model for the sequencer bench
`timescale 1ns/1ps
module i2cms_slave (
  input  wire logic       scl,      // clock line level
  input  wire logic       sda,      // data line level
  input  wire logic       nack,     // ack level given as receiver
  input  wire logic       clash,    // pull data low on written bits
  input  wire logic [7:0] rd_byte,  // byte returned on a read
  output logic            sda_pull, // high pulls data low
  output logic [7:0]      got       // last byte taken in
);
  logic [7:0] sh_r;       // incoming bits
  int         bitn = 0;   // clock rises in this byte
  logic       first = 1'b1;  // address byte next
  logic       dir = 1'b0;    // 1 when master reads
  logic       drv = 1'b0;    // sending data bits
  logic       mack = 1'b1;   // level on ninth bit
  logic       pull = 1'b0;   // driving the line low
  logic       wph = 1'b0;    // master writing data
  // ------------------------------------------------
  // line events
  // ------------------------------------------------
  assign sda_pull = pull | (wph & clash);
  // start or repeated start restarts the byte
  always @(negedge sda) if (scl) begin
    bitn = 0;
    first = 1;
    {pull, drv, wph} = 3'h0;
  end
  // stop releases the line
  always @(posedge sda) if (scl) {pull, drv, wph} = 3'h0;
  // sample on rising clock
  always @(posedge scl) begin
    if (bitn < 8) sh_r = {sh_r[6:0], sda};
    else mack = sda;
    bitn = bitn + 1;
  end
  // change the line only while the clock is low
  always @(negedge scl) begin
    if (bitn == 8) begin  // ack slot
      if (first) dir = sh_r[0];
      got = sh_r;
      pull = (dir && !first) ? 1'b0 : !nack;
      wph = 1'b0;
    end else if (bitn == 9) begin  // byte done, a master nack ends sending
      drv = dir && !mack;
      first = 0;
      bitn = 0;
      pull = drv && !rd_byte[7];
      wph = !dir;
    end else if (bitn > 0 && bitn < 8 && drv) begin
      pull = !rd_byte[7 - bitn];
    end
  end
endmodule : i2cms_slave

/* verification/i2cms_top_tb.sv */
// self-checking bench for the i2c master sequencer
`timescale 1ns/1ps
module i2cms_top_tb;
  import i2cms_pkg::*;
  typedef struct packed {
    logic       spd;   // speed select
    logic [1:0] red;   // speed reduction
    logic [7:0] adr;   // address and direction
    logic [7:0] tx;    // written byte
    logic       ackv;  // ack level on read
    logic       nack;  // slave ack level
    logic [7:0] rd;    // slave read byte
    logic [7:0] hi;    // clock high time
  } i2cms_tb_row_t;
  logic       clk, rst_n, fast_sys_clock, iface_enable_bit, speed_select_bit;
  logic       slowdown_sel_hi, slowdown_sel_lo, clock_sync_select, ack_drive_value;
  logic       ctrl_wr, ctrl_go, ctrl_halt, ctrl_restart, xfer_go_bit, ack_seen_bit;
  logic       arb_error_flag, bus_busy_flag, bus_iface_irq, scl_in, scl_out, scl_oe;
  logic       sda_in, sda_out, sda_oe, s_nack, s_clash, s_pull;
  logic [7:0] target_addr, tx_data, rx_data, s_rd, s_got, hcnt, hi_last;
  int         fails, compares, cyc;
  // one row per transfer: write, read, nack, std mode
  i2cms_tb_row_t rows [5] = '{
    '{1'b1, 2'h0, 8'ha4, 8'h5a, 1'b0, 1'b0, 8'h00, 8'h08},
    '{1'b1, 2'h1, 8'ha5, 8'h00, 1'b1, 1'b0, 8'h3c, 8'h08},
    '{1'b1, 2'h2, 8'h4e, 8'hc3, 1'b0, 1'b1, 8'h00, 8'h0a},
    '{1'b1, 2'h3, 8'h4f, 8'h00, 1'b0, 1'b0, 8'h96, 8'h0a},
    '{1'b0, 2'h0, 8'h32, 8'h81, 1'b0, 1'b0, 8'h00, 8'h24}};
  // ------------------------------------------------
  // clocks, lines, monitors
  // ------------------------------------------------
  always #2.5 clk = ~clk;
  initial begin
    #13.3;
    forever #40 fast_sys_clock = ~fast_sys_clock;
  end
  assign scl_in = !scl_oe;
  assign sda_in = !(sda_oe | s_pull);
  // length of the last clock high phase, in link cycles
  always @(posedge fast_sys_clock) begin
    if (scl_in) hcnt <= hcnt + 8'h01;
    else if (hcnt != 8'h00) begin
      hi_last <= hcnt;
      hcnt <= 8'h00;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      end_sim();
    end
  end
  i2cms_top dut (.clk, .rst_n, .fast_sys_clock, .iface_enable_bit, .speed_select_bit,
    .slowdown_sel_hi, .slowdown_sel_lo, .clock_sync_select, .target_addr, .tx_data,
    .ack_drive_value, .ctrl_wr, .ctrl_go, .ctrl_halt, .ctrl_restart, .xfer_go_bit,
    .rx_data, .ack_seen_bit, .arb_error_flag, .bus_busy_flag, .bus_iface_irq, .scl_in,
    .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);
  i2cms_slave slv (.scl(scl_in), .sda(sda_in), .nack(s_nack), .clash(s_clash),
    .rd_byte(s_rd), .sda_pull(s_pull), .got(s_got));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk1(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  task automatic cfg(input i2cms_tb_row_t r);
    @(posedge clk);
    speed_select_bit <= r.spd;
    {slowdown_sel_hi, slowdown_sel_lo} <= r.red;
    target_addr <= r.adr;
    tx_data <= r.tx;
    ack_drive_value <= r.ackv;
    s_nack <= r.nack;
    s_rd <= r.rd;
  endtask : cfg
  // one control write, then the spacing the command crossing needs
  task automatic ctl(input logic g, input logic h, input logic r);
    @(posedge clk);
    {ctrl_wr, ctrl_go, ctrl_halt, ctrl_restart} <= {1'b1, g, h, r};
    @(posedge clk);
    ctrl_wr <= 1'b0;
    repeat (4) @(posedge fast_sys_clock);
  endtask : ctl
  task automatic wait_irq();
    int n;
    n = 0;
    @(negedge clk);
    while (bus_iface_irq !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk1("bus_iface_irq", 1'b1, bus_iface_irq);
    repeat (2) @(negedge clk);
  endtask : wait_irq
  task automatic run_row(input i2cms_tb_row_t r);
    cfg(r);
    ctl(1'b1, 1'b0, 1'b0);
    chk1("xfer_go_bit", 1'b1, xfer_go_bit);
    wait_irq();
    chk8("rx_data", r.adr, rx_data);
    chk1("ack_seen_bit", r.nack, ack_seen_bit);
    chk8("slave addr", r.adr, s_got);
    chk1("scl_in", 1'b0, scl_in);
    chk1("bus_busy_flag", 1'b1, bus_busy_flag);
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk8("rx_data", r.adr[0] ? r.rd : r.tx, rx_data);
    chk1("ack_seen_bit", r.adr[0] ? r.ackv : r.nack, ack_seen_bit);
    chk8("slave data", r.adr[0] ? r.rd : r.tx, s_got);
    chk8("scl high", r.hi, hi_last);
    ctl(1'b0, 1'b1, 1'b0);
    wait_irq();
    repeat (60) @(posedge fast_sys_clock);
    chk1("bus_busy_flag", 1'b0, bus_busy_flag);
    chk1("xfer_go_bit", 1'b0, xfer_go_bit);
  endtask : run_row
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {clk, rst_n, iface_enable_bit, speed_select_bit, slowdown_sel_hi} = 5'h00;
    {slowdown_sel_lo, clock_sync_select, ack_drive_value, ctrl_wr} = 4'h0;
    {ctrl_go, ctrl_halt, ctrl_restart, s_nack, s_clash} = 5'h00;
    {target_addr, tx_data, s_rd, hcnt, hi_last} = 40'h0;
    {fails, compares, cyc} = '0;
    fast_sys_clock = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge fast_sys_clock);
    chk8("rx_data", RX_RST, rx_data);
    chk1("bus_busy_flag", 1'b0, bus_busy_flag);
    ctl(1'b1, 1'b0, 1'b0);
    chk1("xfer_go_bit", 1'b0, xfer_go_bit);
    @(posedge clk);
    iface_enable_bit <= 1'b1;
    repeat (4) @(posedge fast_sys_clock);
    foreach (rows[i]) run_row(rows[i]);
    // repeated start from the wait state, then a nacked read
    cfg(i2cms_tb_row_t'{1'b1, 2'h0, 8'ha4, 8'h00, 1'b1, 1'b0, 8'hf0, 8'h08});
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    cfg(i2cms_tb_row_t'{1'b1, 2'h0, 8'ha5, 8'h00, 1'b1, 1'b0, 8'hf0, 8'h08});
    ctl(1'b1, 1'b0, 1'b1);
    wait_irq();
    chk8("rx_data", 8'ha5, rx_data);
    chk8("slave addr", 8'ha5, s_got);
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk8("rx_data", 8'hf0, rx_data);
    chk1("ack_seen_bit", 1'b1, ack_seen_bit);
    ctl(1'b0, 1'b1, 1'b0);
    wait_irq();
    repeat (60) @(posedge fast_sys_clock);  // bus-free time before idle
    // lost arbitration: slave holds data low under written ones
    cfg(i2cms_tb_row_t'{1'b1, 2'h0, 8'ha4, 8'hff, 1'b0, 1'b1, 8'h00, 8'h08});
    clock_sync_select <= 1'b1;
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    s_clash = 1'b1;
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk1("arb_error_flag", 1'b1, arb_error_flag);
    chk8("rx_data", 8'h00, rx_data);
    s_clash = 1'b0;
    ctl(1'b0, 1'b1, 1'b0);
    chk1("arb_error_flag", 1'b0, arb_error_flag);
    wait_irq();
    repeat (60) @(posedge fast_sys_clock);  // bus-free time before idle
    // enable dropped in mid-transfer clears status and receive data and releases both lines
    ctl(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk1("ack_seen_bit", 1'b1, ack_seen_bit);
    @(posedge clk);
    iface_enable_bit <= 1'b0;
    repeat (6) @(posedge fast_sys_clock);
    @(negedge clk);
    chk8("rx_data", RX_RST, rx_data);
    chk1("ack_seen_bit", 1'b0, ack_seen_bit);
    chk1("bus_busy_flag", 1'b0, bus_busy_flag);
    chk1("scl_oe", 1'b0, scl_oe);
    chk1("sda_oe", 1'b0, sda_oe);
    chk1("scl_out", 1'b0, scl_out);
    chk1("sda_out", 1'b0, sda_out);
    end_sim();
  end
endmodule : i2cms_top_tb
